// *** logic/spe_dev.sv ***
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module spe_dev
  import spe_pkg::*;
#(
  parameter int TWC_CYCLES = TWC_CYC
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // serial link
  spe_link_if.dev   link,
  // state view
  output logic [7:0] devState
);

  typedef enum logic [3:0] {
    S_CMD   = 4'h0,
    S_ADH   = 4'h1,
    S_ADL   = 4'h2,
    S_RDATA = 4'h3,
    S_RDST  = 4'h4,
    S_WST   = 4'h5,
    S_WDONE = 4'h6,
    S_PAGE  = 4'h7,
    S_IGN   = 4'h8
  } spe_fe_e;

  // ==========================================================
  // pin synchronisers and edges
  logic [3:0] pinS;
  logic       csAct, csN, sck, sdi, wpN, sckD, csD;
  logic       sckRise, sckFall, csFall, csRise;

  spe_sync #(.W(4)) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .d       ({~link.csN, link.sck, link.sdi, link.wpN}),
    .q       (pinS)
  );
  // select passes the flops active high so reset reads as deselected
  assign {csAct, sck, sdi, wpN} = pinS;
  assign csN = ~csAct;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sckD <= 1'b0;
      csD  <= 1'b1;
    end else begin
      sckD <= sck;
      csD  <= csN;
    end
  end
  assign sckRise = sck & ~sckD & ~csN;
  assign sckFall = ~sck & sckD & ~csN;
  assign csFall  = ~csN & csD;
  assign csRise  = csN & ~csD;

  // ==========================================================
  // storage
  logic [7:0]        mem     [0:(1<<ADDR_W)-1];
  logic [7:0]        pageBuf [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] pageValid;

  // ==========================================================
  // front end
  spe_fe_e           fsm;
  logic [2:0]        bitCnt, outBit;
  logic [6:0]        shIn;
  logic [7:0]        inByte, outSh, wstData;
  logic [5:0]        addrHi;
  logic [ADDR_W-1:0] addr;
  logic              opRead, byteDone;
  logic              wel, busy, lock;
  logic [1:0]        prot;
  logic [7:0]        stateByte;

  assign inByte    = {shIn, sdi};
  assign byteDone  = sckRise && bitCnt == 3'h7;
  assign stateByte = {lock, 3'h0, prot, wel, busy};

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fsm       <= S_IGN;
      bitCnt    <= 3'h0;
      shIn      <= 7'h0;
      opRead    <= 1'b0;
      addrHi    <= 6'h0;
      addr      <= '0;
      outSh     <= 8'h0;
      outBit    <= 3'h0;
      wstData   <= 8'h0;
      pageValid <= '0;
      link.sdo   <= 1'b0;
      link.sdoOe <= 1'b0;
    end else if (csN) begin
      link.sdoOe <= 1'b0;
    end else if (csFall) begin
      fsm    <= S_CMD;
      bitCnt <= 3'h0;
    end else begin
      if (sckRise) begin
        shIn   <= inByte[6:0];
        bitCnt <= bitCnt + 3'h1;
        if (fsm == S_WDONE) begin
          fsm <= S_IGN;
        end
      end
      if (byteDone) begin
        unique case (fsm)
          S_CMD: begin
            fsm <= S_IGN;
            if (inByte == OP_READ_STATE) begin
              fsm    <= S_RDST;
              outSh  <= stateByte;
              outBit <= 3'h0;
            end else if (!busy && (inByte == OP_READ
                                 || inByte == OP_PAGE)) begin
              fsm    <= S_ADH;
              opRead <= inByte == OP_READ;
            end else if (!busy && inByte == OP_WRITE_STATE) begin
              fsm <= S_WST;
            end
          end
          S_ADH: begin
            addrHi <= inByte[5:0];
            fsm    <= S_ADL;
          end
          S_ADL: begin
            addr <= {addrHi, inByte};
            if (opRead) begin
              fsm    <= S_RDATA;
              outSh  <= mem[{addrHi, inByte}];
              outBit <= 3'h0;
            end else begin
              fsm       <= S_PAGE;
              pageValid <= '0;
            end
          end
          S_WST: begin
            wstData <= inByte;
            fsm     <= S_WDONE;
          end
          S_PAGE: begin
            pageValid[addr[5:0]] <= 1'b1;
            addr[5:0]            <= addr[5:0] + 6'h1;
          end
          S_RDATA, S_RDST, S_WDONE, S_IGN: begin
          end
          default: fsm <= S_IGN;
        endcase
      end
      if (sckFall && (fsm == S_RDATA || fsm == S_RDST)) begin
        link.sdoOe <= 1'b1;
        link.sdo   <= outSh[7];
        outSh      <= {outSh[6:0], 1'b0};
        outBit     <= outBit + 3'h1;
        if (outBit == 3'h7) begin
          if (fsm == S_RDST) begin
            outSh <= stateByte;
          end else begin
            addr  <= addr + 14'h1;
            outSh <= mem[addr + 14'h1];
          end
        end
      end
    end
  end

  // ==========================================================
  // latch, state register and write engine
  logic        cmdSet, cmdClr, goState, goPage, copyPage;
  logic [20:0] timer;
  logic [6:0]  copyIdx;
  logic        pageProt;

  always_comb begin
    unique case (prot)
      2'h0: pageProt = 1'b0;
      2'h1: pageProt = addr >= PROT_QUART;
      2'h2: pageProt = addr >= PROT_HALF;
      2'h3: pageProt = 1'b1;
    endcase
  end

  assign cmdSet  = byteDone && fsm == S_CMD && !busy
                   && inByte == OP_SET_LATCH;
  assign cmdClr  = byteDone && fsm == S_CMD && !busy
                   && inByte == OP_CLR_LATCH;
  assign goState = csRise && fsm == S_WDONE && bitCnt == 3'h0
                   && wel && wpN;
  assign goPage  = csRise && fsm == S_PAGE && bitCnt == 3'h0
                   && |pageValid && wel && !pageProt;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wel      <= 1'b0;
      busy     <= 1'b0;
      prot     <= PROT_RESET;
      lock     <= LOCK_RESET;
      timer    <= 21'h0;
      copyIdx  <= 7'h0;
      copyPage <= 1'b0;
    end else if (busy) begin
      timer <= timer - 21'h1;
      if (copyIdx != 7'(PAGE_BYTES)) begin
        copyIdx <= copyIdx + 7'h1;
      end
      if (timer == 21'h0) begin
        busy <= 1'b0;
        wel  <= 1'b0;
      end
    end else begin
      if (cmdSet) begin
        wel <= 1'b1;
      end else if (cmdClr) begin
        wel <= 1'b0;
      end
      if (goState || goPage) begin
        busy     <= 1'b1;
        timer    <= 21'(TWC_CYCLES - 1);
        copyIdx  <= 7'h0;
        copyPage <= goPage;
      end
      if (goState) begin
        prot <= {wstData[ST_PROT_HI], wstData[ST_PROT_LO]};
        lock <= wstData[ST_LOCK];
      end
    end
  end

  // ==========================================================
  // array and page buffer
  always_ff @(posedge ref_clk) begin
    if (byteDone && fsm == S_PAGE) begin
      pageBuf[addr[5:0]] <= inByte;
    end
    if (busy && copyPage && copyIdx != 7'(PAGE_BYTES)
        && pageValid[copyIdx[5:0]]) begin
      mem[{addr[13:6], copyIdx[5:0]}] <= pageBuf[copyIdx[5:0]];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      devState <= 8'h0;
    end else begin
      devState <= stateByte;
    end
  end

endmodule

// *** logic/spe_pkg.sv ***
// Notes on behaviour
// - 06h sets, 04h clears latch, 05h reads state
// - 01h then one byte writes state register
// - 03h, high then low address, returns data
// - 02h, address, then 1 to 64 bytes
// - top two address bits are ignored
// - first read bit on last address fall
// - sample on rises 0-23, drive on falls
// - address increments while clocks continue
// - address wraps to 0000h past the top
// - chip select high ends cycle, output released
// - state layout: busy, latch, level, lock
// - reset clears busy, latch, reserved bits
// - lock is only stored and read back; pin low blocks state writes; level protects
// - state read allowed while busy
// - state bits start after eighth command bit
// - state shifts out bit7 down to bit0
// - state output repeats until deselect
// - 06h sets latch, 04h clears latch
// - state write at deselect, pin high, latch set
// - latch clears when any write completes
// - levels 01/10/11 guard 3000h up, 2000h up, all
package spe_pkg;

  // ==========================================================
  // command codes
  localparam logic [7:0] OP_WRITE_STATE = 8'h01;
  localparam logic [7:0] OP_PAGE        = 8'h02;
  localparam logic [7:0] OP_READ        = 8'h03;
  localparam logic [7:0] OP_CLR_LATCH   = 8'h04;
  localparam logic [7:0] OP_READ_STATE  = 8'h05;
  localparam logic [7:0] OP_SET_LATCH   = 8'h06;

  // ==========================================================
  // state register fields
  localparam int         ST_BUSY    = 0;
  localparam int         ST_LATCH   = 1;
  localparam int         ST_PROT_LO = 2;
  localparam int         ST_PROT_HI = 3;
  localparam int         ST_LOCK    = 7;
  localparam logic [1:0] PROT_RESET = 2'h0;
  localparam logic       LOCK_RESET = 1'b0;

  // ==========================================================
  // array geometry and protected areas
  localparam int          ADDR_W     = 14;
  localparam int          PAGE_BYTES = 64;
  localparam logic [13:0] PROT_QUART = 14'h3000;
  localparam logic [13:0] PROT_HALF  = 14'h2000;

  // ==========================================================
  // timing
  localparam int CLK_NS      = 4;
  localparam int TWC_MS      = 5;
  localparam int TWC_CYC     = TWC_MS * 1000000 / CLK_NS;
  localparam int SCK_NS      = 200;
  localparam int SCK_HALF    = SCK_NS / (2 * CLK_NS);
  localparam int CSS_NS      = 90;
  localparam int CSS_CYC     = (CSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CSH_NS      = 90;
  localparam int CSH_CYC     = (CSH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CPH_NS      = 90;
  localparam int CPH_CYC     = (CPH_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // host register map
  localparam logic [7:0] HREG_DATA = 8'h00;
  localparam logic [7:0] HREG_CTRL = 8'h04;
  localparam int         CTRL_END  = 0;
  localparam int         CTRL_WP   = 1;
  localparam int         HST_BUSY  = 0;
  localparam int         HST_OPEN  = 1;
  localparam int         HST_WP    = 2;

endpackage

// *** logic/spe_link_if.sv ***
`timescale 1ns/1ns
interface spe_link_if;
  logic csN;
  logic sck;
  logic sdi;
  logic wpN;
  logic sdo;
  logic sdoOe;
  logic soLine;

  // released output line reads as pulled high
  assign soLine = sdoOe ? sdo : 1'b1;

  modport host (
    output csN, sck, sdi, wpN,
    input  soLine
  );
  modport dev (
    input  csN, sck, sdi, wpN,
    output sdo, sdoOe
  );
endinterface

// *** logic/spe_sync.sv ***
`timescale 1ns/1ns
module spe_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// *** logic/spe_host.sv ***
`timescale 1ns/1ns
module spe_host
  import spe_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // serial link
  spe_link_if.host        link
);

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_SETUP = 3'h1,
    H_LOW   = 3'h2,
    H_HIGH  = 3'h3,
    H_OPEN  = 3'h4,
    H_CSH   = 3'h5,
    H_CPH   = 3'h6
  } spe_host_e;

  spe_host_e  st;
  logic [4:0] cnt;
  logic [2:0] bitNo;
  logic [7:0] txSh, rxSh, rxByte;
  logic       soS, wrData, wrEnd, busyH;

  spe_sync #(.W(1)) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .d       (link.soLine),
    .q       (soS)
  );

  assign wrData = regWr && regAddr == HREG_DATA;
  assign wrEnd  = regWr && regAddr == HREG_CTRL && regWdata[CTRL_END];
  assign busyH  = st != H_IDLE && st != H_OPEN;

  // ==========================================================
  // register port
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 8'h0;
      link.wpN <= 1'b1;
    end else begin
      regRdata <= 8'h0;
      if (regRd && regAddr == HREG_DATA) begin
        regRdata <= rxByte;
      end else if (regRd && regAddr == HREG_CTRL) begin
        regRdata[HST_BUSY] <= busyH;
        regRdata[HST_OPEN] <= ~link.csN;
        regRdata[HST_WP]   <= link.wpN;
      end
      if (regWr && regAddr == HREG_CTRL) begin
        link.wpN <= regWdata[CTRL_WP];
      end
    end
  end

  // ==========================================================
  // byte shifter, mode 0, msb first
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st       <= H_IDLE;
      cnt      <= 5'h0;
      bitNo    <= 3'h0;
      txSh     <= 8'h0;
      rxSh     <= 8'h0;
      rxByte   <= 8'h0;
      link.csN <= 1'b1;
      link.sck <= 1'b0;
      link.sdi <= 1'b0;
    end else begin
      cnt <= cnt + 5'h1;
      unique case (st)
        H_IDLE: begin
          if (wrData) begin
            link.csN <= 1'b0;
            txSh     <= regWdata;
            st       <= H_SETUP;
            cnt      <= 5'h0;
          end
        end
        H_SETUP: begin
          if (cnt == 5'(CSS_CYC - 1)) begin
            link.sdi <= txSh[7];
            bitNo    <= 3'h0;
            st       <= H_LOW;
            cnt      <= 5'h0;
          end
        end
        H_OPEN: begin
          if (wrData) begin
            txSh     <= regWdata;
            link.sdi <= regWdata[7];
            bitNo    <= 3'h0;
            st       <= H_LOW;
            cnt      <= 5'h0;
          end else if (wrEnd) begin
            st  <= H_CSH;
            cnt <= 5'h0;
          end
        end
        H_LOW: begin
          if (cnt == 5'(SCK_HALF - 1)) begin
            link.sck <= 1'b1;
            rxSh     <= {rxSh[6:0], soS};
            st       <= H_HIGH;
            cnt      <= 5'h0;
          end
        end
        H_HIGH: begin
          if (cnt == 5'(SCK_HALF - 1)) begin
            link.sck <= 1'b0;
            cnt      <= 5'h0;
            txSh     <= {txSh[6:0], 1'b0};
            if (bitNo == 3'h7) begin
              rxByte <= rxSh;
              st     <= H_OPEN;
            end else begin
              link.sdi <= txSh[6];
              bitNo    <= bitNo + 3'h1;
              st       <= H_LOW;
            end
          end
        end
        H_CSH: begin
          if (cnt == 5'(CSH_CYC - 1)) begin
            link.csN <= 1'b1;
            st       <= H_CPH;
            cnt      <= 5'h0;
          end
        end
        H_CPH: begin
          if (cnt == 5'(CPH_CYC - 1)) begin
            st <= H_IDLE;
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end

endmodule

// *** bench/spe_link_monitor.sv ***
`timescale 1ns/1ns
module spe_link_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // link wires
  input wire logic csN,
  input wire logic sck,
  input wire logic sdi,
  input wire logic wpN,
  input wire logic sdo,
  input wire logic sdoOe,
  input wire logic soLine
);
  // ==========================================================
  // serial clock rises since chip select fell
  logic [7:0] riseCnt;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      riseCnt <= 8'h00;
    end else if (csN) begin
      riseCnt <= 8'h00;
    end else if ($rose(sck) && riseCnt != 8'hff) begin
      riseCnt <= riseCnt + 8'h01;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  AST_OE_COUNT: assert property ($rose(sdoOe) |->
    riseCnt == 8'h08 || riseCnt == 8'h18)
    else $error("output enabled at wrong clock count");
  AST_OE_ON_FALL: assert property ($rose(sdoOe) |-> !sck)
    else $error("output enabled while clock high");
  AST_OE_HOLD: assert property (sdoOe && !csN |=> sdoOe)
    else $error("output dropped while selected");
  AST_RELEASE: assert property (csN [*8] |-> !sdoOe)
    else $error("output still driven after deselect");
  AST_OE_SELECTED: assert property ($rose(sdoOe) |-> !csN)
    else $error("output enabled while deselected");
  AST_SDO_ON_FALL: assert property (
    sck && $past(sck) && sdoOe |-> $stable(sdo))
    else $error("output changed while clock high");
  AST_SDI_HELD: assert property (sck && $past(sck) |-> $stable(sdi))
    else $error("input data changed while clock high");
  AST_CS_QUIET: assert property ($changed(csN) |-> !sck && !$past(sck))
    else $error("chip select moved while clock high");
  AST_CS_SETUP: assert property ($fell(csN) |=> !sck [*8])
    else $error("clock rose too soon after select");
  AST_LINE_PULL: assert property (!sdoOe |-> soLine)
    else $error("released output line not pulled high");

  cover property ($rose(sdoOe) && riseCnt == 8'h18);
  cover property ($rose(sdoOe) && riseCnt == 8'h08);
  cover property ($rose(csN) && riseCnt == 8'h10);
  cover property ($rose(csN) && !wpN);
endmodule

// *** bench/spi_eeprom_read_status_bench.sv ***
`timescale 1ns/1ns
module spi_eeprom_read_status_bench;
  import spe_pkg::*;
  // ==========================================================
  // signals
  logic       ref_clk;
  logic       arst_n;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdata;
  logic [7:0] devState;
  logic [7:0] rx;
  logic [7:0] rxq[$];
  logic       wpLvl;
  int         num_errors;
  int         comparisons;

  spe_link_if link ();
  spe_host u_spe_host (.ref_clk(ref_clk), .arst_n(arst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .link(link.host));
  // short write time keeps busy visible across one state read
  spe_dev #(.TWC_CYCLES(2000)) u_spe_dev (.ref_clk(ref_clk),
    .arst_n(arst_n), .link(link.dev), .devState(devState));
  spe_link_monitor u_spe_link_monitor (.ref_clk(ref_clk),
    .arst_n(arst_n), .csN(link.csN), .sck(link.sck), .sdi(link.sdi),
    .wpN(link.wpN), .sdo(link.sdo), .sdoOe(link.sdoOe),
    .soLine(link.soLine));

  always #2 ref_clk = ~ref_clk;

  // ==========================================================
  // tasks
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  // poll host control until the masked flags are clear
  task automatic waitHost(input logic [7:0] mask);
    logic [7:0] s;
    do regRead(HREG_CTRL, s);
    while ((s & mask) !== 8'h00);
  endtask

  // one frame: every byte sent, every received byte kept in rxq
  task automatic frame(input logic [7:0] tx[$]);
    logic [7:0] d;
    rxq.delete();
    foreach (tx[i]) begin
      regWrite(HREG_DATA, tx[i]);
      waitHost(8'h01);
      regRead(HREG_DATA, d);
      rxq.push_back(d);
    end
    regWrite(HREG_CTRL, {6'h00, wpLvl, 1'b1});
    waitHost(8'h03);
    rx = d;
  endtask

  task automatic readState();
    frame('{OP_READ_STATE, 8'h00});
  endtask

  task automatic waitReady();
    do readState();
    while (rx[ST_BUSY] !== 1'b0);
  endtask

  task automatic stop_test();
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    repeat (95000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end

  // ==========================================================
  // tests
  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    wpLvl = 1'b1;
    num_errors = 0;
    comparisons = 0;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    frame('{OP_READ_STATE, 8'h00, 8'h00});
    check("state at reset", rxq[1], 8'h00);
    check("state repeat", rxq[2], 8'h00);
    frame('{OP_SET_LATCH});
    frame('{OP_READ_STATE, 8'h00, 8'h00});
    check("latch set", rxq[1], 8'h02);
    check("latch repeat", rxq[2], 8'h02);
    frame('{OP_CLR_LATCH});
    readState();
    check("latch clear", rx, 8'h00);
    frame('{OP_SET_LATCH});
    frame('{OP_WRITE_STATE});
    readState();
    check("abandoned write", rx, 8'h02);
    wpLvl = 1'b0;
    frame('{OP_WRITE_STATE, 8'h84});
    wpLvl = 1'b1;
    readState();
    check("guard pin low", rx, 8'h02);
    frame('{OP_WRITE_STATE, 8'hf4});
    readState();
    check("busy polled", rx & 8'h01, 8'h01);
    waitReady();
    check("state written", rx, 8'h84);
    check("state view", devState, 8'h84);
    frame('{OP_SET_LATCH});
    frame('{OP_PAGE, 8'h3f, 8'hfe, 8'h11});
    readState();
    check("protected page", rx, 8'h86);
    frame('{OP_WRITE_STATE, 8'h00});
    waitReady();
    check("protect off", rx, 8'h00);
    frame('{OP_SET_LATCH});
    frame('{OP_PAGE, 8'hff, 8'hfe, 8'ha5, 8'h5a});
    waitReady();
    frame('{OP_SET_LATCH});
    frame('{OP_PAGE, 8'hc0, 8'h00, 8'hc3});
    waitReady();
    frame('{OP_READ, 8'h7f, 8'hfe, 8'h00, 8'h00, 8'h00});
    check("read first", rxq[3], 8'ha5);
    check("read next", rxq[4], 8'h5a);
    check("read wrapped", rxq[5], 8'hc3);
    readState();
    check("state after read", rx, 8'h00);
    regRead(8'h08, rx);
    check("unmapped read", rx, 8'h00);
    stop_test();
  end
endmodule
